// [core/clk_ctrl_pkg.sv]
package clk_ctrl_pkg;
  // timing
  localparam int SYS_FREQ_HZ   = 100_000_000;
  localparam int WDT_FREQ_HZ   = 128_000;
  localparam int WDT_DIV       = SYS_FREQ_HZ / WDT_FREQ_HZ;
  localparam int DIV8_RATIO    = 8;
  localparam int TOUT_SHORT_CYC = 4096;
  localparam int TOUT_LONG_CYC  = 8192;
  localparam int EXT_START_CK  = 6;
  localparam int RC_START_CK   = 6;
  localparam int RES_SHORT_CK  = 258;
  localparam int RES_LONG_CK   = 1024;
  localparam int XTAL_START_CK = 16384;
  localparam int LF_START_CK   = 32768;
  localparam int CNT_W         = 16;
  localparam int DIV_W         = 16;

  // fuse polarity and shipped defaults
  localparam logic       FUSE_PROG   = 1'b0;
  localparam logic [3:0] SRC_F_RESET   = 4'h2;
  localparam logic [1:0] START_F_RESET = 2'h2;
  localparam logic       DIV8_RESET  = 1'b0;

  // register map
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  REG_SLEEP     = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h4;
  localparam int          ST_SRC_LSB    = 0;
  localparam int          ST_START_LSB  = 4;
  localparam int          ST_DIV8_BIT   = 6;
  localparam int          ST_ILLEGAL_BIT = 7;
  localparam int          ST_STATE_LSB  = 8;
  localparam int          ST_RESET_BIT  = 12;
  localparam logic [2:0]  SLEEP_CODES   = 3'h6;

  // gate vector positions
  localparam int G_CORE = 0;
  localparam int G_PERI = 1;
  localparam int G_PROG = 2;
  localparam int G_ASY  = 3;
  localparam int G_CONV = 4;

  typedef enum logic [2:0] {
    sm_active, sm_idle, sm_adc_noise, sm_power_down, sm_power_save,
    sm_standby
  } sleep_mode_e;

  typedef enum logic [2:0] {
    src_ext, src_reserved, src_rc_cal, src_rc128k, src_lf_xtal,
    src_full_xtal, src_lp_xtal
  } source_e;
endpackage

// [core/cnt_if.sv]
`timescale 1ns/1ps
interface cnt_if #(parameter int W = 16);
  logic         clear;
  logic         tick;
  logic [W-1:0] target;
  logic         done;
  modport ctrl (output clear, output tick, output target, input done);
  modport cnt  (input clear, input tick, input target, output done);
endinterface

// [core/tick_divider.sv]
`timescale 1ns/1ps
module tick_divider
  import clk_ctrl_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] divisor,
  output logic              tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } div_s;
  div_s q;
  div_s n;

  always_comb
  begin
    n = q;
    n.tick = 1'b0;
    if (q.cnt >= divisor - W'(1))
    begin
      n.cnt = '0;
      n.tick = 1'b1;
    end
    else
      n.cnt = q.cnt + W'(1);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= n;
  end

  assign tick = q.tick;
endmodule

// [core/startup_counter.sv]
`timescale 1ns/1ps
module startup_counter
  import clk_ctrl_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic sys_clk,
  input  wire logic rst,
  cnt_if.cnt        c
);
  typedef struct packed {
    logic [W-1:0] count;
  } cnt_s;
  cnt_s q;
  cnt_s n;

  // counts tick pulses, saturates at target
  always_comb
  begin
    n = q;
    if (c.clear)
      n.count = '0;
    else if (c.tick && q.count != c.target)
      n.count = q.count + W'(1);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= n;
  end

  assign c.done = (q.count == c.target);
endmodule

// [core/clock_select_and_startup_delay.sv]
// Functional notes
// - decode the four-bit source field into the seven source kinds.
// - fuse bit 1 means unprogrammed, 0 means programmed.
// - shipped default is calibrated RC, divide-by-eight programmed, field 0010.
// - shipped default startup field is 10, longest time-out.
// - internal reset held; time-out starts only after other sources release.
// - time-out counted in watchdog cycles, length from both fuse fields.
// - time-out lengths are 0, 4096 or 8192 watchdog cycles.
// - time-out releases on count only; a supply drop sends it back to hold.
// - supply drop detector holds reset; zero time-out then allowed.
// - selected source feeds the core, peripheral, program memory and converter domains.
// - unused domain clocks gated according to the sleep mode.
// - peripheral clock drives timers; some interrupts detected asynchronously.
// - serial start detection async when halted; address match always.
// - program memory clock runs together with core clock.
// - async timer domain fed by external source, runs during idle, noise reduction and power-save sleep.
// - converter domain keeps running in noise reduction sleep.
// - after time-out, source cycle count holds reset before execution.
// - wake from power-save or power-down uses only start-up count.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
module clock_select_and_startup_delay
  import clk_ctrl_pkg::*;
#(
  parameter int XTAL_START = XTAL_START_CK,
  parameter int LF_START   = LF_START_CK,
  parameter int TOUT_LONG  = TOUT_LONG_CYC,
  parameter int TOUT_SHORT = TOUT_SHORT_CYC,
  parameter int WDT_RATIO  = WDT_DIV
)(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [3:0]        clock_source_select_fuses,
  input  wire logic [1:0]        startup_time_fuses,
  input  wire logic              divide_by_eight_fuse,
  input  wire logic              other_reset_req,
  input  wire logic              supply_drop_hold,
  input  wire logic              sleep_enter,
  input  wire logic              wake_evt,
  input  wire logic              async_src_tick,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic                   internal_reset,
  output logic                   core_clock,
  output logic                   peripheral_clock,
  output logic                   program_memory_clock,
  output logic                   async_timer_clock,
  output logic                   converter_clock,
  output source_e                source_kind,
  output logic                   async_irq_detect_en,
  output logic                   serial_start_async_en,
  output logic                   two_wire_addr_match_en
);
  typedef enum logic [2:0] {
    st_hold, st_timeout, st_startup, st_run, st_sleep, st_wake
  } state_e;

  typedef struct packed {
    state_e      st;
    sleep_mode_e mode;
    logic [3:0]  src_f;
    logic [1:0]  start_f;
    logic        div8;
    logic        illegal;
    logic        rst_out;
    logic [4:0]  gate;
    logic [31:0] rdata;
  } ctl_s;

  ctl_s q;
  ctl_s n;

  cnt_if #(.W(CNT_W)) ctr ();

  logic wdt_tick;
  logic div_tick;
  logic sys_tick;
  logic other_any;
  logic illegal_now;

  function automatic source_e decode_src(input logic [3:0] f);
    source_e s;
    s = src_reserved;
    if (f[3])
      s = src_lp_xtal;
    else if (f[2:1] == 2'h3)
      s = src_full_xtal;
    else if (f[2:1] == 2'h2)
      s = src_lf_xtal;
    else if (f == 4'h3)
      s = src_rc128k;
    else if (f == 4'h2)
      s = src_rc_cal;
    else if (f == 4'h0)
      s = src_ext;
    return s;
  endfunction

  // watchdog cycles; full and low-power crystal rows use source bit 0 as a third select bit
  function automatic logic [CNT_W-1:0] tout_cycles(input logic [3:0] f,
                                                   input logic [1:0] s);
    logic [2:0]       idx;
    logic [CNT_W-1:0] t;
    idx = {f[0], s};
    t = CNT_W'(TOUT_LONG);
    if (f[3] || f[2:1] == 2'h3)
    begin
      if (idx == 3'h2 || idx == 3'h5)
        t = '0;
      else if (idx == 3'h0 || idx == 3'h3 || idx == 3'h6)
        t = CNT_W'(TOUT_SHORT);
    end
    else if (s == 2'h0)
      t = '0;
    else if (s == 2'h1)
      t = CNT_W'(TOUT_SHORT);
    return t;
  endfunction

  function automatic logic [CNT_W-1:0] start_cycles(input logic [3:0] f,
                                                    input logic [1:0] s);
    logic [2:0]       idx;
    logic [CNT_W-1:0] t;
    idx = {f[0], s};
    t = CNT_W'(RC_START_CK);
    case (decode_src(f))
      src_ext:     t = CNT_W'(EXT_START_CK);
      src_lf_xtal: t = CNT_W'(LF_START);
      src_lp_xtal, src_full_xtal:
      begin
        if (idx <= 3'h1)
          t = CNT_W'(RES_SHORT_CK);
        else if (idx <= 3'h4)
          t = CNT_W'(RES_LONG_CK);
        else
          t = CNT_W'(XTAL_START);
      end
      default:     t = CNT_W'(RC_START_CK);
    endcase
    return t;
  endfunction

  tick_divider #(.W(DIV_W)) u_wdt_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .divisor (DIV_W'(WDT_RATIO)),
    .tick    (wdt_tick)
  );

  tick_divider #(.W(DIV_W)) u_sys_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .divisor (DIV_W'(DIV8_RATIO)),
    .tick    (div_tick)
  );

  startup_counter #(.W(CNT_W)) u_cnt (
    .sys_clk (sys_clk),
    .rst     (rst),
    .c       (ctr)
  );

  // supply detector is just another reset source here
  assign other_any = other_reset_req | supply_drop_hold;
  assign illegal_now = decode_src(clock_source_select_fuses)
                       == src_reserved;
  assign sys_tick = (q.div8 == FUSE_PROG) ? div_tick : 1'b1;

  // counter paces in watchdog cycles during time-out, source cycles else
  assign ctr.tick = (q.st == st_timeout) ? wdt_tick : 1'b1;
  assign ctr.target = (q.st == st_timeout) ? tout_cycles(q.src_f, q.start_f)
                                           : start_cycles(q.src_f, q.start_f);
  assign ctr.clear = (n.st != q.st) || (q.st == st_hold);

  always_comb
  begin
    n = q;
    n.rdata = '0;
    case (q.st)
      st_hold:
      begin
        // fuses follow the pins only while held, stable afterwards
        n.src_f = clock_source_select_fuses;
        n.start_f = startup_time_fuses;
        n.div8 = divide_by_eight_fuse;
        n.illegal = illegal_now;
        if (!illegal_now)
          n.st = st_timeout;
      end
      st_timeout:
        if (ctr.done)
          n.st = st_startup;
      st_startup:
        if (ctr.done)
          n.st = st_run;
      st_run:
        if (sleep_enter)
          n.st = st_sleep;
      st_sleep:
        if (wake_evt)
        begin
          if (q.mode == sm_power_down || q.mode == sm_power_save)
            n.st = st_wake;
          else
            n.st = st_run;
        end
      st_wake:
        if (ctr.done)
          n.st = st_run;
      default:
        n.st = st_hold;
    endcase
    if (other_any)
      n.st = st_hold;
    n.rst_out = (n.st == st_hold) || (n.st == st_timeout)
                || (n.st == st_startup);

    // domain gating; async timer is the only one alive in power-save
    n.gate = '0;
    if (n.st == st_run)
      n.gate = 5'h1f;
    else if (n.st == st_sleep)
    begin
      case (n.mode)
        sm_idle:
        begin
          n.gate[G_PERI] = 1'b1;
          n.gate[G_ASY] = 1'b1;
          n.gate[G_CONV] = 1'b1;
        end
        sm_adc_noise:
        begin
          n.gate[G_ASY] = 1'b1;
          n.gate[G_CONV] = 1'b1;
        end
        sm_power_save:
          n.gate[G_ASY] = 1'b1;
        sm_active:
          n.gate = 5'h1f;
        default:
          n.gate = '0;
      endcase
    end

    if (reg_wr && reg_addr == REG_SLEEP && reg_wdata[2:0] < SLEEP_CODES)
      n.mode = sleep_mode_e'(reg_wdata[2:0]);
    if (reg_rd)
    begin
      if (reg_addr == REG_SLEEP)
        n.rdata = {29'h0, q.mode};
      else if (reg_addr == REG_STATUS)
      begin
        n.rdata[ST_SRC_LSB +: 4] = q.src_f;
        n.rdata[ST_START_LSB +: 2] = q.start_f;
        n.rdata[ST_DIV8_BIT] = q.div8;
        n.rdata[ST_ILLEGAL_BIT] = q.illegal;
        n.rdata[ST_STATE_LSB +: 3] = q.st;
        n.rdata[ST_RESET_BIT] = q.rst_out;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.st <= st_hold;
      q.mode <= sm_active;
      q.src_f <= SRC_F_RESET;
      q.start_f <= START_F_RESET;
      q.div8 <= DIV8_RESET;
      q.rst_out <= 1'b1;
    end
    else
      q <= n;
  end

  assign reg_rdata = q.rdata;
  assign internal_reset = q.rst_out;
  assign source_kind = decode_src(q.src_f);
  assign core_clock = q.gate[G_CORE] & sys_tick;
  assign program_memory_clock = q.gate[G_PROG] & sys_tick;
  assign peripheral_clock = q.gate[G_PERI] & sys_tick;
  assign converter_clock = q.gate[G_CONV] & sys_tick;
  assign async_timer_clock = q.gate[G_ASY] & async_src_tick;
  assign async_irq_detect_en = ~q.gate[G_PERI];
  assign serial_start_async_en = ~q.gate[G_PERI];
  assign two_wire_addr_match_en = 1'b1;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_sleep_deep;
    q.st == st_sleep && (q.mode == sm_power_down
                         || q.mode == sm_power_save);
  endsequence
  sequence s_wake_path;
    wake_evt && !other_any ##1 q.st == st_wake;
  endsequence

  property p_hold_on_other;
    other_any |=> internal_reset && q.st == st_hold;
  endproperty
  a_hold_on_other: assert property (p_hold_on_other)
    else $error("reset not held while another source active");

  property p_restart;
    (q.st == st_timeout && other_any) |=> ##1 ctr.done == (ctr.target == 0);
  endproperty
  a_restart: assert property (p_restart)
    else $error("time-out count not restarted");

  property p_prog_with_core;
    core_clock == program_memory_clock;
  endproperty
  a_prog_with_core: assert property (p_prog_with_core)
    else $error("program memory clock split from core clock");

  property p_deep_gated;
    q.st == st_sleep && q.mode == sm_power_down
      |-> !core_clock && !peripheral_clock && !converter_clock
          && !async_timer_clock;
  endproperty
  a_deep_gated: assert property (p_deep_gated)
    else $error("clock running in power-down");

  property p_conv_noise;
    (q.st == st_sleep && q.mode == sm_adc_noise && sys_tick)
      |-> converter_clock && !core_clock && !peripheral_clock;
  endproperty
  a_conv_noise: assert property (p_conv_noise)
    else $error("converter domain wrong in noise reduction");

  property p_wake_skip_tout;
    s_sleep_deep ##0 s_wake_path |-> ##1 q.st != st_timeout;
  endproperty
  a_wake_skip_tout: assert property (p_wake_skip_tout)
    else $error("time-out applied on wake");

  property p_div8_spacing;
    core_clock && q.div8 == FUSE_PROG |=> !core_clock [*7];
  endproperty
  a_div8_spacing: assert property (p_div8_spacing)
    else $error("divide-by-eight spacing wrong");

  property p_illegal_held;
    q.illegal && q.st == st_hold |-> internal_reset;
  endproperty
  a_illegal_held: assert property (p_illegal_held)
    else $error("reserved source left reset");

  property p_zero_tout;
    (q.st == st_timeout && ctr.target == 0 && !other_any)
      |=> q.st == st_startup && internal_reset;
  endproperty
  a_zero_tout: assert property (p_zero_tout)
    else $error("zero time-out did not pass at once");

  property p_async_src;
    async_timer_clock |-> async_src_tick && q.gate[G_ASY];
  endproperty
  a_async_src: assert property (p_async_src)
    else $error("async timer clock without its source");
endmodule

// [test/fuse_source_model.sv]
`timescale 1ns/1ps
module fuse_source_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [3:0] src_in,
  input  wire logic [1:0] start_in,
  input  wire logic       div8_in,
  input  wire logic       hold_in,
  input  wire logic       drop_in,
  output logic [3:0]      clock_source_select_fuses,
  output logic [1:0]      startup_time_fuses,
  output logic            divide_by_eight_fuse,
  output logic            other_reset_req,
  output logic            supply_drop_hold,
  output logic            async_src_tick
);
  logic [1:0] div_r;

  // fuse cells hand over raw bits: 0 programmed, 1 erased
  assign clock_source_select_fuses = src_in;
  assign startup_time_fuses        = start_in;
  assign divide_by_eight_fuse      = div8_in;
  assign other_reset_req           = hold_in;
  // detector armed by the bench around zero time-out tests
  assign supply_drop_hold          = drop_in;
  // slow timer source stand-in, one tick in four
  assign async_src_tick            = (div_r == 2'h3);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      div_r <= 2'h0;
    else
      div_r <= div_r + 2'h1;
  end
endmodule

// [test/clock_select_and_startup_delay_bench.sv]
`timescale 1ns/1ps
module clock_select_and_startup_delay_bench;
  import clk_ctrl_pkg::*;
  localparam int TS = 5;
  localparam int TL = 10;
  localparam int WR = 3;
  typedef struct {logic [3:0] c; logic [1:0] s; int t; bit f;} row_s;
  logic        sys_clk, rst, hold, drop, div8, sleep_enter, wake_evt;
  logic        reg_wr, reg_rd, internal_reset, core_clock;
  logic        peripheral_clock, program_memory_clock, async_timer_clock;
  logic        converter_clock, async_irq_detect_en, serial_start_async_en;
  logic        two_wire_addr_match_en, ck_f, dv_f, hr, bh, at;
  logic [3:0]  src_pin, reg_addr, ck_p;
  logic [1:0]  start_pin, su_p;
  logic [31:0] reg_wdata, reg_rdata, d;
  source_e     source_kind;
  int          err_count, n_checks, n, base, rc0;
  int          cnt[5];
  logic [6:0]  slp[5] = '{{3'h1, 4'h7}, {3'h2, 4'h3}, {3'h3, 4'h0},
                          {3'h4, 4'h1}, {3'h5, 4'h0}};
  row_s        rows[9] = '{'{4'h2, 2'h0, 0, 1}, '{4'h2, 2'h1, TS, 0},
    '{4'h2, 2'h2, TL, 0}, '{4'h2, 2'h3, TL, 0}, '{4'h0, 2'h0, 0, 1},
    '{4'h0, 2'h2, TL, 0}, '{4'h6, 2'h0, TS, 1}, '{4'h6, 2'h1, TL, 0},
    '{4'h7, 2'h3, TL, 1}};

  fuse_source_model PM (.sys_clk(sys_clk), .rst(rst), .src_in(src_pin),
    .start_in(start_pin), .div8_in(div8), .hold_in(hold), .drop_in(drop),
    .clock_source_select_fuses(ck_p), .startup_time_fuses(su_p),
    .divide_by_eight_fuse(dv_f), .other_reset_req(hr),
    .supply_drop_hold(bh), .async_src_tick(at));

  clock_select_and_startup_delay #(.XTAL_START(20), .LF_START(30),
    .TOUT_LONG(TL), .TOUT_SHORT(TS), .WDT_RATIO(WR)) DUT (
    .sys_clk(sys_clk), .rst(rst), .clock_source_select_fuses(ck_p),
    .startup_time_fuses(su_p), .divide_by_eight_fuse(dv_f),
    .other_reset_req(hr), .supply_drop_hold(bh),
    .sleep_enter(sleep_enter), .wake_evt(wake_evt), .async_src_tick(at),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .internal_reset(internal_reset), .core_clock(core_clock),
    .peripheral_clock(peripheral_clock),
    .program_memory_clock(program_memory_clock),
    .async_timer_clock(async_timer_clock),
    .converter_clock(converter_clock), .source_kind(source_kind),
    .async_irq_detect_en(async_irq_detect_en),
    .serial_start_async_en(serial_start_async_en),
    .two_wire_addr_match_en(two_wire_addr_match_en));

  task automatic wrap_up();
    $display("mismatches %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi)
    begin
      err_count++;
      $display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // lets a back-to-back write raise the strobe in a later time step
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic pulse(input bit w);
    if (w)
      wake_evt <= 1'b1;
    else
      sleep_enter <= 1'b1;
    @(posedge sys_clk);
    wake_evt <= 1'b0;
    sleep_enter <= 1'b0;
  endtask

  // bounded wait for reset release, counted from the current edge
  task automatic meas(output int k);
    k = 0;
    while (k < 12000)
    begin
      @(posedge sys_clk);
      #1;
      k++;
      if (internal_reset === 1'b0)
        break;
    end
    if (internal_reset !== 1'b0)
    begin
      err_count++;
      wrap_up();
    end
  endtask

  task automatic arm(input logic [3:0] c, input logic [1:0] s);
    src_pin <= c;
    start_pin <= s;
    hold <= 1'b1;
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic boot(input logic [3:0] c, input logic [1:0] s);
    arm(c, s);
    chk(internal_reset, 1'b1);
    hold <= 1'b0;
    meas(n);
  endtask

  task automatic cnt16();
    cnt = '{default: 0};
    repeat (16)
    begin
      @(posedge sys_clk);
      #1;
      cnt[0] += int'(core_clock);
      cnt[1] += int'(peripheral_clock);
      cnt[2] += int'(program_memory_clock);
      cnt[3] += int'(converter_clock);
      cnt[4] += int'(async_timer_clock);
    end
  endtask

  function automatic source_e exp_src(input int c);
    if (c >= 8)
      return src_lp_xtal;
    if (c >= 6)
      return src_full_xtal;
    if (c >= 4)
      return src_lf_xtal;
    case (c)
      3: return src_rc128k;
      2: return src_rc_cal;
      1: return src_reserved;
      default: return src_ext;
    endcase
  endfunction

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial
  begin
    #1_000_000;
    err_count++;
    wrap_up();
  end

  initial
  begin
    {rst, hold, drop, div8, sleep_enter, wake_evt, reg_wr, reg_rd} = 8'hc0;
    {src_pin, start_pin, reg_addr, reg_wdata} = {4'h2, 2'h2, 4'h0, 32'h0};
    repeat (6) @(posedge sys_clk);
    chk(internal_reset, 1'b1);
    chk(core_clock, 1'b0);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    hold <= 1'b0;
    meas(n);
    chk(internal_reset, 1'b0);
    rd(REG_STATUS, d);
    chk(d[6:0], {1'b0, 2'h2, 4'h2});
    cnt16();
    chk(cnt[0], 2);
    rd(4'h8, d);
    chk(d, 32'h0);
    wr(REG_SLEEP, 32'h1);
    wr(REG_SLEEP, 32'h6);
    rd(REG_SLEEP, d);
    chk(d[2:0], 3'h1);
    for (int i = 0; i < 16; i++)
    begin
      arm(i[3:0], 2'h0);
      chk(source_kind, exp_src(i));
    end
    arm(4'h1, 2'h0);
    hold <= 1'b0;
    repeat (60) @(posedge sys_clk);
    chk(internal_reset, 1'b1);
    rd(REG_STATUS, d);
    chk(d[ST_ILLEGAL_BIT], 1'b1);
    div8 <= 1'b1;
    foreach (rows[i])
    begin
      boot(rows[i].c, rows[i].s);
      if (rows[i].f)
        base = n - rows[i].t * WR;
      if (i == 0)
        rc0 = n;
      chk_rng(n - base, (rows[i].t - 1) * WR, (rows[i].t + 1) * WR);
      chk(source_kind, exp_src(rows[i].c));
    end
    // other source drops back in mid count: full length again
    arm(4'h2, 2'h2);
    hold <= 1'b0;
    repeat (15) @(posedge sys_clk);
    hold <= 1'b1;
    repeat (2) @(posedge sys_clk);
    hold <= 1'b0;
    meas(n);
    chk_rng(n, rc0 + (TL - 1) * WR, rc0 + (TL + 1) * WR);
    arm(4'h2, 2'h0);
    drop <= 1'b1;
    hold <= 1'b0;
    repeat (60) @(posedge sys_clk);
    chk(internal_reset, 1'b1);
    drop <= 1'b0;
    meas(n);
    chk_rng(n, rc0 - WR, rc0 + WR);
    cnt16();
    for (int k = 0; k < 4; k++)
      chk(cnt[k], 16);
    chk(cnt[4], 4);
    foreach (slp[i])
    begin
      wr(REG_SLEEP, {29'h0, slp[i][6:4]});
      pulse(1'b0);
      repeat (2) @(posedge sys_clk);
      cnt16();
      chk(cnt[0] != 0, slp[i][3]);
      chk(cnt[1] != 0, slp[i][2]);
      chk(cnt[3] != 0, slp[i][1]);
      chk(cnt[4] != 0, slp[i][0]);
      chk(cnt[2], cnt[0]);
      chk(async_irq_detect_en, !slp[i][2]);
      chk(serial_start_async_en, !slp[i][2]);
      chk(two_wire_addr_match_en, 1'b1);
      pulse(1'b1);
      // step off the wake edge so the new gate value has settled
      #1;
      n = 0;
      while (n < 200 && core_clock !== 1'b1)
      begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      if (core_clock !== 1'b1)
      begin
        err_count++;
        wrap_up();
      end
      if (slp[i][6:4] == 3'h3 || slp[i][6:4] == 3'h4)
        chk_rng(n, RC_START_CK + 1, RC_START_CK + 1);
      else
        chk_rng(n, 0, 0);
    end
    wrap_up();
  end
endmodule
